// ### design/hom_demux.sv
// Demultiplexer end: alignment, destuffing, alarm and parity extraction.
// Assumes the line strobe comes from logic on the same clock.
`timescale 1ns/10ps
`include "hom_defs.svh"

module hom_demux
  import hom_pkg::*;
#(
  parameter int LOSS_FRAMES   = `HOM_LOSS_FRAMES,
  parameter int GAIN_FRAMES   = `HOM_GAIN_FRAMES,
  parameter int AIS_MAX_ZEROS = `HOM_AIS_MAX_ZEROS
) (
  input  wire logic        clk,            // 250 MHz system clock.
  input  wire logic        reset,          // Synchronous, active high.
  hom_line_if.demux        line,           // Serial multiplex input.
  output logic [2:0]       trib_data,      // Recovered tributary bits.
  output logic [2:0]       trib_valid,     // One-cycle strobe per bit.
  output logic             lof,            // Frame alignment lost.
  output logic             prompt_alarm,   // Local maintenance alarm.
  output logic             rdi_req,        // Ask local mux to send alarm.
  output logic             far_alarm,      // Alarm bit seen from far end.
  output logic             ais_det,        // All-ones signal received.
  output logic             parity_err      // One-cycle parity mismatch.
);
  hom_align_e      st_r;
  hom_pos_s        pos_r;
  logic [10:0]     sr_r;
  logic [1:0]      tsel_r;
  logic [2:0]      hits_r;
  logic [2:0]      miss_r;
  logic [4:0]      cbits_r [3];
  logic            par_acc_r;
  logic            par_prev_r;
  logic [9:0]      win_r;
  logic [9:0]      zeros_r;
  logic [2:0]      td_r;
  logic [2:0]      tv_r;
  logic            lof_r;
  logic            pma_r;
  logic            far_r;
  logic            ais_r;
  logic            perr_r;

  wire       v        = line.line_valid;
  wire       b        = line.line_bit;
  wire       fa_ok    = {sr_r, b} == `HOM_FAW;
  wire       at_chk   = pos_r.set == 3'h0 && pos_r.pos == 8'(`HOM_FAW_LEN);
  wire       pay      = hom_is_payload(pos_r);
  wire       just_now = hom_maj5(cbits_r[tsel_r]);
  wire       discard  = hom_is_just_slot(pos_r) && just_now;
  wire       set4     = pos_r.set == 3'(`HOM_AIS_SET);
  wire       frm_end  = pos_r.set == 3'(`HOM_SETS - 1) && pos_r.pos == 8'(`HOM_SET_BITS);
  wire [1:0] ctl_idx  = pos_r.pos[1:0] - 2'h1;
  wire [2:0] ctl_set  = pos_r.set - 3'h1;
  wire       in_lof   = st_r != HOM_SYNC;
  wire       win_end  = win_r == 10'(`HOM_FRAME_BITS - 1);
  wire       at_ctrl  = hom_is_ctrl(pos_r);
  wire       at_alarm = set4 && pos_r.pos == 8'(`HOM_ALARM_POS);
  wire       at_par   = set4 && pos_r.pos == 8'(`HOM_PARITY_POS);
  wire       found    = st_r == HOM_SEARCH && fa_ok;
  // A search match or a frame end restarts the tributary cycle at tributary
  // one, so a stray match cannot leave every later frame skewed.
  wire       restart  = frm_end || found;

  // All outputs are registers; rdi_req mirrors lof so a local mux can carry
  // it straight onto its outgoing alarm bit.
  assign trib_data    = td_r;
  assign trib_valid   = tv_r;
  assign lof          = lof_r;
  assign prompt_alarm = pma_r;
  assign rdi_req      = lof_r;
  assign far_alarm    = far_r;
  assign ais_det      = ais_r;
  assign parity_err   = perr_r;

  // Search re-anchors on a match anywhere; confirm and hold look only at the
  // predicted slot, so a single stray match costs at most two frames.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r   <= HOM_SEARCH;
      pos_r  <= '{set: 3'h0, pos: 8'h01};
      sr_r   <= '0;
      hits_r <= 3'h0;
      miss_r <= 3'h0;
    end else if (v) begin
      sr_r  <= {sr_r[9:0], b};
      pos_r <= hom_next(pos_r);
      unique case (st_r)
        HOM_SEARCH: begin
          if (fa_ok) begin
            pos_r  <= '{set: 3'h0, pos: 8'(`HOM_FAW_LEN + 1)};
            st_r   <= HOM_CONFIRM;
            hits_r <= 3'h1;
          end
        end
        HOM_CONFIRM: begin
          if (at_chk && !fa_ok) begin
            st_r <= HOM_SEARCH;
          end else if (at_chk && hits_r == 3'(GAIN_FRAMES - 1)) begin
            st_r   <= HOM_SYNC;
            miss_r <= 3'h0;
          end else if (at_chk) begin
            hits_r <= hits_r + 3'h1;
          end
        end
        HOM_SYNC: begin
          if (at_chk && fa_ok) begin
            miss_r <= 3'h0;
          end else if (at_chk && miss_r == 3'(LOSS_FRAMES - 1)) begin
            st_r <= HOM_SEARCH;
          end else if (at_chk) begin
            miss_r <= miss_r + 3'h1;
          end
        end
      endcase
    end
  end

  // Payload, control, alarm and parity extraction.
  always_ff @(posedge clk) begin
    if (reset) begin
      tsel_r     <= 2'h0;
      cbits_r    <= '{default: 5'h00};
      par_acc_r  <= 1'b0;
      par_prev_r <= 1'b0;
      far_r      <= 1'b0;
      perr_r     <= 1'b0;
      td_r       <= 3'h7;
      tv_r       <= 3'h0;
    end else begin
      tv_r   <= 3'h0;
      perr_r <= 1'b0;
      if (v && pay) begin
        tsel_r <= (tsel_r == 2'h2) ? 2'h0 : tsel_r + 2'h1;
        if (!discard) begin
          tv_r[tsel_r] <= 1'b1;
          td_r[tsel_r] <= in_lof ? 1'b1 : b;
        end
      end
      if (v && restart) begin
        tsel_r <= 2'h0;
      end
      // The vote at the slots reads a column filled earlier in the same frame.
      if (v && at_ctrl) begin
        cbits_r[ctl_idx][ctl_set] <= b;
      end
      if (v && at_alarm) begin
        far_r <= b;
      end
      // Parity is judged only in alignment; a frame seen in search has no trusted sum.
      if (v && at_par && !in_lof) begin
        perr_r <= b != par_prev_r;
      end
      if (v && frm_end) begin
        par_prev_r <= par_acc_r ^ b;
        par_acc_r  <= 1'b0;
      end else if (v && pay) begin
        par_acc_r <= par_acc_r ^ b;
      end
    end
  end

  // Counts zeros over free-running frame-length windows. A framed all-ones
  // payload still holds six zeros in the alignment word, so a low limit
  // separates it from a true all-ones signal with occasional errors.
  always_ff @(posedge clk) begin
    if (reset) begin
      win_r   <= 10'h000;
      zeros_r <= 10'h000;
      ais_r   <= 1'b0;
      lof_r   <= 1'b1;
      pma_r   <= 1'b0;
    end else begin
      lof_r <= in_lof;
      // Loss is expected under an all-ones signal, so it raises no local alarm.
      pma_r <= in_lof && !ais_r;
      if (v) begin
        win_r   <= win_end ? 10'h000 : win_r + 10'h001;
        zeros_r <= win_end ? 10'h000 : zeros_r + 10'(!b);
        if (win_end) begin
          ais_r <= (zeros_r + 10'(!b)) <= 10'(AIS_MAX_ZEROS);
        end
      end
    end
  end
endmodule

// ### design/hom_defs.svh
// Frame layout and timing constants shared by both ends of the muldex framer.
// Assumes nothing; definitions only.
`ifndef HOM_DEFS_SVH
`define HOM_DEFS_SVH

`define HOM_TRIBS          3
`define HOM_SETS           6
`define HOM_SET_BITS       159
`define HOM_FRAME_BITS     954
`define HOM_TRIB_BITS      307
`define HOM_FAW            12'hfa0
`define HOM_FAW_LEN        12
`define HOM_CTRL_LAST      3
`define HOM_AIS_SET        3
`define HOM_ALARM_POS      4
`define HOM_PARITY_POS     5
`define HOM_RSV_FIRST      6
`define HOM_RSV_LAST       9
`define HOM_JUST_SET       5
`define HOM_JUST_FIRST     4
`define HOM_JUST_LAST      6
`define HOM_PAY_FIRST_S1   13
`define HOM_PAY_FIRST      4
`define HOM_PAY_FIRST_S4   10
`define HOM_PAY_FIRST_S6   7
`define HOM_LOSS_FRAMES    4
`define HOM_GAIN_FRAMES    3
`define HOM_FIFO_DEPTH     16
`define HOM_STUFF_THRESH   8
`define HOM_AIS_MAX_ZEROS  4

`endif

// ### design/hom_pkg.sv
// Types and shared decoding for the muldex framer.
// Assumes hom_defs.svh is on the include path.
`include "hom_defs.svh"

package hom_pkg;

  typedef struct packed {
    logic [2:0] set;  // 0..5 for sets one to six
    logic [7:0] pos;  // 1..159 within a set
  } hom_pos_s;

  typedef enum logic [2:0] {
    HOM_SEARCH  = 3'b001,
    HOM_CONFIRM = 3'b010,
    HOM_SYNC    = 3'b100
  } hom_align_e;

  function automatic hom_pos_s hom_next(input hom_pos_s p);
    hom_pos_s n;
    n = p;
    if (p.pos == 8'(`HOM_SET_BITS)) begin
      n.pos = 8'h01;
      n.set = (p.set == 3'(`HOM_SETS - 1)) ? 3'h0 : p.set + 3'h1;
    end else begin
      n.pos = p.pos + 8'h01;
    end
    return n;
  endfunction

  // Payload includes the justifiable slots of set six.
  function automatic logic hom_is_payload(input hom_pos_s p);
    logic r;
    r = 1'b0;
    unique case (p.set)
      3'h0:    r = p.pos >= 8'(`HOM_PAY_FIRST_S1);
      3'h3:    r = p.pos >= 8'(`HOM_PAY_FIRST_S4);
      default: r = p.pos >= 8'(`HOM_PAY_FIRST);
    endcase
    return r;
  endfunction

  function automatic logic hom_is_just_slot(input hom_pos_s p);
    return p.set == 3'(`HOM_JUST_SET) && p.pos >= 8'(`HOM_JUST_FIRST) && p.pos <= 8'(`HOM_JUST_LAST);
  endfunction

  function automatic logic hom_is_ctrl(input hom_pos_s p);
    return p.set != 3'h0 && p.pos <= 8'(`HOM_CTRL_LAST);
  endfunction

  function automatic logic hom_maj5(input logic [4:0] v);
    logic [2:0] n;
    n = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
    return n >= 3'h3;
  endfunction

endpackage

// ### design/hom_line_if.sv
// Serial multiplex line between multiplexer and demultiplexer.
// Assumes both ends run on the same clock; one line bit per strobe.
`timescale 1ns/10ps
interface hom_line_if;
  logic line_bit;    // Serial multiplex bit, frame bit 1 first.
  logic line_valid;  // High in each cycle that carries a line bit.
  modport mux (output line_bit, output line_valid);
  modport demux (input line_bit, input line_valid);
endinterface

// ### design/hom_mux.sv
// Multiplexer end: elastic FIFO per tributary and the frame builder.
// Assumes tributary bits arrive on clk with valid/ready handshakes.
`timescale 1ns/10ps
`include "hom_defs.svh"

module hom_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = `HOM_FIFO_DEPTH
) (
  input  wire logic                       clk,        // System clock.
  input  wire logic                       reset,      // Synchronous reset.
  input  wire logic [WIDTH-1:0]           in_data,    // Write data.
  input  wire logic                       in_valid,   // Write request.
  output logic                            in_ready,   // Space available.
  output logic [WIDTH-1:0]                out_data,   // Head word.
  output logic                            out_valid,  // Head word present.
  input  wire logic                       out_ready,  // Read acknowledge.
  output logic [$clog2(DEPTH+1)-1:0]      level       // Words held.
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [CW-1:0]    cnt_r;
  logic             in_ready_r;
  wire              push = in_valid && in_ready_r;
  wire              pop = out_ready && out_valid;
  wire [CW-1:0]     cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  assign in_ready  = in_ready_r;
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rd_r];
  assign level     = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Ready is registered so the source never sees a combinational path.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_r       <= '0;
      rd_r       <= '0;
      cnt_r      <= '0;
      in_ready_r <= 1'b0;
    end else begin
      wr_r       <= push ? ((wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1)) : wr_r;
      rd_r       <= pop ? ((rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1)) : rd_r;
      cnt_r      <= cnt_nxt;
      in_ready_r <= cnt_nxt < CW'(DEPTH);
    end
  end
endmodule

module hom_mux
  import hom_pkg::*;
#(
  parameter int FIFO_DEPTH   = `HOM_FIFO_DEPTH,
  parameter int STUFF_THRESH = `HOM_STUFF_THRESH
) (
  input  wire logic        clk,           // 250 MHz system clock.
  input  wire logic        reset,         // Synchronous, active high.
  input  wire logic [2:0]  trib_data,     // One bit per tributary.
  input  wire logic [2:0]  trib_valid,    // Tributary bit offered.
  output logic [2:0]       trib_ready,    // Tributary FIFO has room.
  input  wire logic        alarm_req,     // Local fault: send remote alarm.
  hom_line_if.mux          line           // Serial multiplex output.
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  // A literal cannot be bit-selected, so the word is held as a constant.
  localparam logic [11:0] FAW = `HOM_FAW;

  hom_pos_s        pos_r;
  logic [1:0]      tsel_r;
  logic [2:0]      stuff_r;
  logic            par_acc_r;
  logic            par_prev_r;
  logic            bit_r;
  logic            valid_r;
  logic [2:0]      head;
  logic [2:0]      head_ok;
  logic [2:0]      pop;
  logic [CW-1:0]   lvl [3];

  for (genvar j = 0; j < 3; j++) begin : g_fifo
    hom_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_data   (trib_data[j]),
      .in_valid  (trib_valid[j]),
      .in_ready  (trib_ready[j]),
      .out_data  (head[j]),
      .out_valid (head_ok[j]),
      .out_ready (pop[j]),
      .level     (lvl[j])
    );
  end

  wire pay       = hom_is_payload(pos_r);
  wire stuffed   = hom_is_just_slot(pos_r) && stuff_r[tsel_r];
  wire frm_start = pos_r.set == 3'h0 && pos_r.pos == 8'h01;
  wire frm_end   = pos_r.set == 3'(`HOM_SETS - 1) && pos_r.pos == 8'(`HOM_SET_BITS);
  wire in_faw    = pos_r.set == 3'h0 && pos_r.pos <= 8'(`HOM_FAW_LEN);
  wire [3:0] faw_idx = 4'(`HOM_FAW_LEN) - pos_r.pos[3:0];
  wire set4      = pos_r.set == 3'(`HOM_AIS_SET);
  wire [1:0] ctl_idx = pos_r.pos[1:0] - 2'h1;
  // A starved FIFO sends ones rather than stalling the line.
  wire pay_bit   = stuffed ? 1'b1 : (head_ok[tsel_r] ? head[tsel_r] : 1'b1);

  logic out_bit;
  always_comb begin
    out_bit = 1'b1;
    if (in_faw) begin
      out_bit = FAW[faw_idx];
    end else if (hom_is_ctrl(pos_r)) begin
      out_bit = stuff_r[ctl_idx];
    end else if (set4 && pos_r.pos == 8'(`HOM_ALARM_POS)) begin
      out_bit = alarm_req;
    end else if (set4 && pos_r.pos == 8'(`HOM_PARITY_POS)) begin
      out_bit = par_prev_r;
    end else if (pay) begin
      out_bit = pay_bit;
    end
  end

  assign pop = (pay && !stuffed && head_ok[tsel_r]) ? 3'(1) << tsel_r : 3'h0;
  assign line.line_bit   = bit_r;
  assign line.line_valid = valid_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      pos_r      <= '{set: 3'h0, pos: 8'h01};
      tsel_r     <= 2'h0;
      stuff_r    <= 3'h0;
      par_acc_r  <= 1'b0;
      par_prev_r <= 1'b0;
      bit_r      <= 1'b1;
      valid_r    <= 1'b0;
    end else begin
      pos_r   <= hom_next(pos_r);
      bit_r   <= out_bit;
      valid_r <= 1'b1;
      if (pay) begin
        tsel_r <= (tsel_r == 2'h2) ? 2'h0 : tsel_r + 2'h1;
      end
      // Decided before set two carries the first control bits.
      if (frm_start) begin
        for (int j = 0; j < 3; j++) begin
          stuff_r[j] <= lvl[j] < CW'(STUFF_THRESH);
        end
      end
      if (frm_end) begin
        par_prev_r <= par_acc_r ^ out_bit;
        par_acc_r  <= 1'b0;
      end else if (pay) begin
        par_acc_r <= par_acc_r ^ out_bit;
      end
    end
  end
endmodule

// ### verif/hom_line_props.sv
// Checker for the serial multiplex line between the two framer ends.
// Assumes the mux sends one bit per clock from the edge after reset.
`timescale 1ns/10ps
module hom_line_props (
  input wire logic clk,        // System clock.
  input wire logic reset,      // Synchronous reset, active high.
  input wire logic line_bit,   // Serial line bit.
  input wire logic line_valid  // Line strobe.
);
  logic [9:0] cnt_r;
  logic [2:0] ctl_r;
  logic       acc_r;
  logic       par_r;
  logic       seen_r;
  wire  [2:0] set_w   = 3'(cnt_r / 10'h09f);
  wire  [7:0] pos_w   = 8'(cnt_r - 10'h09f * {7'h00, set_w} + 10'h001);
  wire  [7:0] first_w = (set_w == 3'h0) ? 8'h0d : (set_w == 3'h3) ? 8'h0a : 8'h04;
  wire        last_w  = cnt_r == 10'h3b9;
  wire        ctrl_w  = line_valid && set_w >= 3'h2 && pos_w <= 8'h03;
  wire  [1:0] tj_w    = pos_w[1:0] - 2'h1;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 10'h000;
    end else if (line_valid) begin
      cnt_r <= last_w ? 10'h000 : cnt_r + 10'h001;
    end
  end

  // The first frame after reset has no predecessor, so its parity bit is not judged.
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_r  <= 1'b0;
      par_r  <= 1'b0;
      seen_r <= 1'b0;
    end else if (line_valid && pos_w >= first_w) begin
      acc_r  <= last_w ? 1'b0 : acc_r ^ line_bit;
      par_r  <= last_w ? acc_r ^ line_bit : par_r;
      seen_r <= seen_r | last_w;
    end
  end

  always_ff @(posedge clk) begin
    if (line_valid && set_w == 3'h1 && pos_w <= 8'h03) begin
      ctl_r[tj_w] <= line_bit;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_faw;
    line_bit [*5] ##1 !line_bit ##1 line_bit ##1 !line_bit [*5];
  endsequence
  sequence s_run;
    line_valid [*8];
  endsequence

  property p_start;
    $fell(reset) |=> s_run;
  endproperty
  property p_run;
    line_valid |=> line_valid;
  endproperty
  property p_faw;
    line_valid && cnt_r == 10'h000 |-> s_faw;
  endproperty
  property p_ctrl_mid;
    ctrl_w && set_w != 3'h5 |-> line_bit == ctl_r[tj_w];
  endproperty
  property p_ctrl_last;
    ctrl_w && set_w == 3'h5 |-> line_bit == ctl_r[tj_w];
  endproperty
  property p_rsv;
    line_valid && set_w == 3'h3 && pos_w >= 8'h06 && pos_w <= 8'h09 |-> line_bit;
  endproperty
  property p_stuff;
    line_valid && set_w == 3'h5 && pos_w >= 8'h04 && pos_w <= 8'h06 && ctl_r[pos_w[1:0]] |-> line_bit;
  endproperty
  property p_parity;
    line_valid && seen_r && set_w == 3'h3 && pos_w == 8'h05 |-> line_bit == par_r;
  endproperty

  a_start: assert property (p_start) else $error("line strobe late after reset");
  a_run: assert property (p_run) else $error("line strobe gap");
  a_faw: assert property (p_faw) else $error("alignment word wrong");
  a_ctrl_mid: assert property (p_ctrl_mid) else $error("control bits disagree");
  a_ctrl_last: assert property (p_ctrl_last) else $error("last control bit disagrees");
  a_rsv: assert property (p_rsv) else $error("reserved bit not one");
  a_stuff: assert property (p_stuff) else $error("stuff slot not one");
  a_parity: assert property (p_parity) else $error("parity bit wrong");
endmodule

// ### verif/high_order_muldex_framer_bench.sv
// Bench: mux looped to demux, plus a second demux fed by a frame driver.
// Assumes the header, package, interface and both ends are compiled first.
`timescale 1ns/10ps
`include "hom_defs.svh"
module high_order_muldex_framer_bench;
  localparam logic [11:0] FAW_W = `HOM_FAW;
  logic       clk        = 1'b0;
  logic       reset      = 1'b1;
  logic       alarm_req  = 1'b0;
  logic [2:0] trib_data  = 3'h2;
  logic [2:0] trib_valid = 3'h7;
  logic [9:0] lc         = 10'h000;
  logic       last2      = 1'b0;
  logic       chk_on     = 1'b0;
  logic       chk0       = 1'b1;
  logic       low_seen   = 1'b0;
  logic       acc        = 1'b0;
  logic       fpar       = 1'b0;
  int         stb[3]     = '{0, 0, 0};
  int         fcnt[3]    = '{0, 0, 0};
  int         bad_count  = 0;
  int         checked    = 0;
  int         fpar_n     = 0;
  int         mpar_n     = 0;
  wire  [2:0] trib_ready, o_data, o_valid, f_data;
  wire        o_lof, o_far, o_par, f_lof, f_prompt, f_rdi, f_ais, f_par;

  hom_line_if line_if ();
  hom_line_if bad_if ();
  hom_mux i_hom_mux (.clk(clk), .reset(reset), .trib_data(trib_data), .trib_valid(trib_valid),
    .trib_ready(trib_ready), .alarm_req(alarm_req), .line(line_if.mux));
  hom_demux i_hom_demux (.clk(clk), .reset(reset), .line(line_if.demux), .trib_data(o_data),
    .trib_valid(o_valid), .lof(o_lof), .prompt_alarm(), .rdi_req(), .far_alarm(o_far), .ais_det(),
    .parity_err(o_par));
  hom_demux i_hom_demux_f (.clk(clk), .reset(reset), .line(bad_if.demux), .trib_data(f_data),
    .trib_valid(), .lof(f_lof), .prompt_alarm(f_prompt), .rdi_req(f_rdi), .far_alarm(), .ais_det(f_ais),
    .parity_err(f_par));
  hom_line_props i_hom_line_props (.clk(clk), .reset(reset), .line_bit(line_if.line_bit),
    .line_valid(line_if.line_valid));

  always #2 clk = ~clk;

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Window counts line up with frames because output latency is shorter than the alignment word.
  always @(posedge clk) begin
    if (reset) lc <= 10'h000;
    else if (line_if.line_valid) lc <= (lc == 10'h3b9) ? 10'h000 : lc + 10'h001;
    for (int j = 0; j < 3; j++) begin
      stb[j] <= (line_if.line_valid && lc == 10'h000) ? int'(o_valid[j]) : stb[j] + int'(o_valid[j]);
      if (line_if.line_valid && lc == 10'h000) fcnt[j] <= stb[j];
    end
    if (trib_valid[2] && trib_ready[2]) trib_data[2] <= #1 !trib_data[2];
    if (chk_on && !trib_ready[0]) low_seen <= 1'b1;
    if (f_par) fpar_n <= fpar_n + 1;
    if (chk_on && o_par) mpar_n <= mpar_n + 1;
    if (o_valid[2]) last2 <= o_data[2];
    if (chk_on && o_valid[2]) chk("trib2 bit", {9'h000, !last2}, {9'h000, o_data[2]});
    if (chk_on && o_valid[1]) chk("trib1 bit", 10'h001, {9'h000, o_data[1]});
    if (chk_on && chk0 && o_valid[0]) chk("trib0 bit", 10'h000, {9'h000, o_data[0]});
  end

  task automatic wait_frame();
    do @(posedge clk); while (!(line_if.line_valid && lc == 10'h000));
  endtask

  task automatic frame_counts(input logic [9:0] e0, input logic [9:0] e1, input logic [9:0] e2);
    wait_frame();
    #1;
    chk("trib0 count", e0, 10'(fcnt[0]));
    chk("trib1 count", e1, 10'(fcnt[1]));
    chk("trib2 count", e2, 10'(fcnt[2]));
  endtask

  task automatic drive(input logic b);
    @(posedge clk);
    #1;
    bad_if.line_bit = b;
    bad_if.line_valid = 1'b1;
  endtask

  task automatic send_frame(input logic faw_ok, input logic par_bad, input logic ones);
    logic [7:0] s;
    logic [7:0] p;
    logic       b;
    for (int k = 0; k < `HOM_FRAME_BITS; k++) begin
      s = 8'(k / `HOM_SET_BITS);
      p = 8'(k % `HOM_SET_BITS + 1);
      if (s == 8'h00 && p <= 8'h0c) b = FAW_W[4'(8'h0c - p)] ^ !faw_ok;
      else if (ones) b = 1'b1;
      else if (s != 8'h00 && p <= 8'h03) b = 1'b0;
      else if (s == 8'h03 && p <= 8'h09) b = (p == 8'h05) ? fpar ^ par_bad : p > 8'h05;
      else begin
        b = k[0];
        acc ^= b;
      end
      drive(b);
    end
    fpar = acc;
    acc = 1'b0;
  endtask

  task automatic main_test();
    repeat (5) wait_frame();
    #1;
    chk("lof", 10'h000, {9'h000, o_lof});
    chk_on = 1'b1;
    frame_counts(10'h133, 10'h133, 10'h133);
    chk("fifo full", 10'h001, {9'h000, low_seen});
    @(posedge clk);
    #1;
    trib_valid[0] = 1'b0;
    chk0 = 1'b0;
    repeat (2) wait_frame();
    frame_counts(10'h132, 10'h133, 10'h133);
    chk("fifo room", 10'h001, {9'h000, trib_ready[0]});
    @(posedge clk);
    #1;
    trib_valid[0] = 1'b1;
    repeat (2) wait_frame();
    frame_counts(10'h133, 10'h133, 10'h133);
    chk0 = 1'b1;
    alarm_req = 1'b1;
    repeat (2) wait_frame();
    #1 chk("far alarm", 10'h001, {9'h000, o_far});
    alarm_req = 1'b0;
    repeat (2) wait_frame();
    #1 chk("far alarm", 10'h000, {9'h000, o_far});
    chk("parity errors", 10'h000, 10'(mpar_n));
    $display("test loopback done");
  endtask

  task automatic fault_test();
    repeat (2) send_frame(1'b1, 1'b0, 1'b0);
    chk("lof early", 10'h001, {9'h000, f_lof});
    send_frame(1'b1, 1'b0, 1'b0);
    chk("lof gained", 10'h000, {9'h000, f_lof});
    repeat (3) send_frame(1'b0, 1'b0, 1'b0);
    chk("lof held", 10'h000, {9'h000, f_lof});
    send_frame(1'b0, 1'b0, 1'b0);
    chk("lof lost", 10'h001, {9'h000, f_lof});
    chk("prompt", 10'h001, {9'h000, f_prompt});
    chk("remote req", 10'h001, {9'h000, f_rdi});
    chk("all ones out", 10'h007, {7'h00, f_data});
    send_frame(1'b1, 1'b0, 1'b0);
    send_frame(1'b0, 1'b0, 1'b0);
    repeat (2) send_frame(1'b1, 1'b0, 1'b0);
    chk("lof candidate", 10'h001, {9'h000, f_lof});
    send_frame(1'b1, 1'b0, 1'b0);
    chk("lof regained", 10'h000, {9'h000, f_lof});
    send_frame(1'b1, 1'b0, 1'b0);
    fpar_n = 0;
    send_frame(1'b1, 1'b1, 1'b0);
    send_frame(1'b1, 1'b0, 1'b0);
    chk("parity flags", 10'h001, 10'(fpar_n));
    for (int k = 1; k <= 4000; k++) drive(k % 1000 != 0);
    chk("ais", 10'h001, {9'h000, f_ais});
    chk("lof ais", 10'h001, {9'h000, f_lof});
    chk("prompt ais", 10'h000, {9'h000, f_prompt});
    repeat (2) send_frame(1'b1, 1'b0, 1'b1);
    chk("ais framed", 10'h000, {9'h000, f_ais});
    $display("test fault stream done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    bad_if.line_bit = 1'b1;
    bad_if.line_valid = 1'b0;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    fork
      main_test();
      fault_test();
    join
    summarize();
  end

  // Both tests together need about 21 frames, some 20000 cycles.
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
